// ### dv/pcrc_generator_monitor.sv
// Port checks of the CRC block: bus answer, read values, flags, pulses.
// Assumes it is bound to pcrc_generator and sees only its ports.
`timescale 1ns/10ps
module pcrc_monitor (
   input wire        clk_i,
   input wire        rst_i,
   input wire [3:0]  adr_i,
   input wire [31:0] dat_i,
   input wire [3:0]  sel_i,
   input wire        we_i,
   input wire        cyc_i,
   input wire        stb_i,
   input wire [31:0] dat_o,
   input wire        ack_o,
   input wire        irq_o
);
   reg  [3:0] poly_length_minus_one_reg;
   wire       rd = ack_o && !we_i;
   wire       ctl = rd && adr_i == 4'h0;
   wire [4:0] cnt = dat_o[12:8];
   // The result width follows the length last written over the bus.
   always @(posedge clk_i)
      if (rst_i)
         poly_length_minus_one_reg <= 4'h0;
      else if (ack_o && we_i && adr_i == 4'h0 && sel_i[0])
         poly_length_minus_one_reg <= dat_i[3:0];
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_ack; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
   a_ack: assert property (p_ack) else $error("no ack");
   property p_pulse; ack_o |=> !ack_o; endproperty
   a_pulse: assert property (p_pulse) else $error("long ack");
   property p_zero; rd && (adr_i[1:0] != 2'b00 || adr_i == 4'h8)
      |-> dat_o == 32'h0000_0000; endproperty
   a_zero: assert property (p_zero) else $error("nonzero read");
   property p_tap; rd && adr_i == 4'h4 |-> dat_o[0] == 1'b0; endproperty
   a_tap: assert property (p_tap) else $error("tap bit0 set");
   property p_empty; ctl |-> dat_o[6] == (cnt == 5'h00); endproperty
   a_empty: assert property (p_empty) else $error("empty flag");
   property p_full; ctl |-> dat_o[7] == (cnt == (dat_o[3] ? 5'h08 : 5'h10));
   endproperty
   a_full: assert property (p_full) else $error("full flag");
   property p_res; rd && adr_i == 4'hc
      |-> ((dat_o[15:0] >> poly_length_minus_one_reg) >> 1) == 16'h0000; endproperty
   a_res: assert property (p_res) else $error("result width");
   property p_irq; irq_o |=> !irq_o; endproperty
   a_irq: assert property (p_irq) else $error("long irq");
   c_irq: cover property (irq_o);
   c_full: cover property (ctl && dat_o[7]);
   c_res: cover property (rd && adr_i == 4'hc);
endmodule

// ### dv/pcrc_generator_tb.sv
// Self-checking bench of the CRC block over classic Wishbone.
// Assumes one clock and a slave that answers each request itself.
`timescale 1ns/10ps
module pcrc_generator_tb;
   reg         clk_i = 0, rst_i = 1, we = 0, cyc = 0, stb = 0;
   reg         slp = 0, idl = 0;
   reg  [3:0]  adr = 0, sel = 0;
   reg  [31:0] dat = 0, rd;
   reg  [15:0] crc;
   reg  [7:0]  db;
   reg  [47:0] rows [0:2];
   wire [31:0] dat_o;
   wire        ack_o, irq_o;
   integer     err_count = 0, n_checks = 0, cyc_n = 0, irqs = 0, i;
   pcrc_generator uut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr),
      .dat_i(dat), .sel_i(sel), .we_i(we), .cyc_i(cyc), .stb_i(stb),
      .dat_o(dat_o), .ack_o(ack_o), .sleep_i(slp), .idle_i(idl),
      .irq_o(irq_o));
   initial forever #5 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cyc_n = cyc_n + 1;
      if (irq_o === 1'b1) irqs = irqs + 1;
      if (cyc_n == 20000) begin
         err_count = err_count + 1;
         report_and_stop;
      end
   end
   task wb(input w, input [3:0] a, input [31:0] d, input [3:0] s);
      begin
         @(posedge clk_i);
         {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, s};
         @(posedge clk_i);
         while (ack_o !== 1'b1) @(posedge clk_i);
         rd = dat_o;
         {cyc, stb} <= 2'b00;
      end
   endtask
   task chk(input [31:0] g, input [31:0] e);
      begin
         n_checks = n_checks + 1;
         if (g !== e) begin
            err_count = err_count + 1;
            $display("ERROR %0t got %h want %h", $time, g, e);
         end
      end
   endtask
   task fill(input [3:0] p, input [4:0] n, input [31:0] e);
      begin
         wb(1, 4'h0, {28'h000_0000, p}, 4'h3);
         // Both lanes are written so that a word wider than a byte counts.
         repeat (n) wb(1, 4'h8, 32'h0000_0011, 4'h3);
         wb(0, 4'h0, 32'h0000_0000, 4'h3);
         chk(rd & 32'h0000_1fc0, e);
      end
   endtask
   task report_and_stop;
      begin
         $display("checks %0d errors %0d", n_checks, err_count);
         if (err_count == 0 && n_checks > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask
   // Taps x^2 + x with the constant term always fed back, MSb first.
   function [15:0] nxt(input [15:0] c, input [7:0] d);
      integer b;
      begin
         for (b = 7; b >= 0; b = b - 1)
            c = (c << 1) ^ ((c[7] ^ d[b]) ? 16'h0007 : 16'h0000);
         nxt = c & 16'h00ff;
      end
   endfunction
   initial begin
      rows[0] = {16'h0004, 16'hffff, 16'hfffe};
      rows[1] = {16'h0000, 16'h200f, 16'h204f};
      rows[2] = {16'h0002, 16'hffff, 16'h0000};
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(0, 4'h0, 32'h0000_0000, 4'h3);
      chk(rd, 32'h0000_0040);
      for (i = 0; i < 3; i = i + 1) begin
         wb(1, rows[i][35:32], {16'h0000, rows[i][31:16]}, 4'h3);
         wb(0, rows[i][35:32], 32'h0000_0000, 4'h3);
         chk(rd, {16'h0000, rows[i][15:0]});
      end
      $display("register rows done");
      wb(1, 4'h4, 32'h0000_0006, 4'h3);
      wb(1, 4'h0, 32'h0000_2007, 4'h3);
      crc = 16'h0000;
      db = 8'hc4;
      for (i = 0; i < 3; i = i + 1) begin
         wb(1, 4'h8, {24'h00_0000, db}, 4'h1);
         crc = nxt(crc, db);
         db = db + 8'h5b;
      end
      wb(0, 4'h0, 32'h0000_0000, 4'h3);
      chk(rd & 32'h0000_1f00, 32'h0000_0300);
      wb(1, 4'h0, 32'h0000_2017, 4'h3);
      for (i = 0; i < 2; i = i + 1) begin
         {slp, idl} <= (i == 0) ? 2'b10 : 2'b01;
         repeat (30) @(posedge clk_i);
         wb(0, 4'h0, 32'h0000_0000, 4'h3);
         chk(rd & 32'h0000_1f00, 32'h0000_0300);
         {slp, idl} <= 2'b00;
         @(posedge clk_i);
      end
      rd = 32'h0000_0000;
      while (rd[6] !== 1'b1) wb(0, 4'h0, 32'h0000_0000, 4'h3);
      wb(0, 4'hc, 32'h0000_0000, 4'h3);
      chk(rd, {16'h0000, crc});
      chk(irqs, 32'h0000_0001);
      $display("checksum test done");
      fill(4'h8, 5'h08, 32'h0000_0880);
      fill(4'h8, 5'h01, 32'h0000_0040);
      fill(4'h3, 5'h08, 32'h0000_0800);
      chk(irqs, 32'h0000_0001);
      $display("fifo flag test done");
      // A reset with go clear and words still counted must clear everything.
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      chk(dat_o, 32'h0000_0000);
      chk({30'h0000_0000, ack_o, irq_o}, 32'h0000_0000);
      rst_i <= 1'b0;
      wb(0, 4'h0, 32'h0000_0000, 4'h3);
      chk(rd, 32'h0000_0040);
      $display("reset test done");
      report_and_stop;
   end
endmodule
bind pcrc_generator pcrc_monitor mon (.clk_i(clk_i), .rst_i(rst_i),
   .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .we_i(we_i),
   .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
   .irq_o(irq_o));

// ### logic/pcrc_generator.v
// Programmable CRC generator with word FIFO and serial shifter.
// Assumes a classic Wishbone master on clk_i and power-state levels from
// the clock controller on the same clock.
`timescale 1ns/10ps
`include "pcrc_map.vh"
module pcrc_generator (
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire [3:0]  adr_i,
   input  wire [31:0] dat_i,
   input  wire [3:0]  sel_i,
   input  wire        we_i,
   input  wire        cyc_i,
   input  wire        stb_i,
   output reg  [31:0] dat_o,
   output reg         ack_o,
   input  wire        sleep_i,
   input  wire        idle_i,
   output reg         irq_o
);
   reg  [3:0]  poly_length_minus_one_reg;
   reg         go_reg;
   reg         idle_stop_reg;
   reg  [15:0] taps_reg;
   reg  [15:0] crc_reg;
   reg  [4:0]  count_reg;
   reg  [15:0] fifo_mem [0:15];
   reg  [3:0]  wr_ptr_reg;
   reg  [3:0]  rd_ptr_reg;
   reg  [15:0] shift_reg;
   reg  [3:0]  bit_reg;
   reg         busy_reg;
   reg         pend_irq_reg;
   reg  [15:0] crc_next;
   reg  [15:0] rd_data;
   wire        req      = cyc_i & stb_i & ~ack_o;
   // A write lands at the edge where the master samples ack high, so the
   // register changes together with the end of the bus cycle.
   wire        wr       = cyc_i & stb_i & ack_o & we_i;
   wire        wr_data  = wr & (adr_i == `PCRC_WDATA_ADDR);
   wire [4:0]  depth    = (poly_length_minus_one_reg > `PCRC_POLY_LENGTH_MINUS_ONE_SPLIT) ?
                          `PCRC_DEPTH_SMALL : `PCRC_DEPTH_LARGE;
   wire        full     = (count_reg == depth);
   wire        empty    = (count_reg == 5'h00);
   wire        frozen   = sleep_i | (idle_i & idle_stop_reg);
   // Word is complete once a write covers the lane holding its top bit.
   wire        top_lane = poly_length_minus_one_reg[3] ? sel_i[1] : sel_i[0];
   wire        word_in  = wr_data & top_lane;
   wire        run      = ~frozen & go_reg;
   wire        load     = run & ~busy_reg & ~empty;
   wire        last_bit = run & busy_reg & (bit_reg == 4'h0);
   wire [15:0] len_mask = {1'b1, 15'h7fff} >> (4'hf - poly_length_minus_one_reg);
   wire [15:0] data_in  = {sel_i[1] ? dat_i[15:8] : 8'h00,
                           sel_i[0] ? dat_i[7:0] : 8'h00};
   integer     i;

   // One bit of mod-2 division: feedback is the top remainder bit XOR the
   // incoming data bit, applied to term zero and every enabled tap.
   always @* begin
      crc_next = crc_reg;
      if (run & busy_reg) begin
         crc_next[0] = crc_reg[poly_length_minus_one_reg] ^ shift_reg[poly_length_minus_one_reg];
         for (i = 1; i < 16; i = i + 1) begin
            crc_next[i] = crc_reg[i-1] ^
                          (taps_reg[i] & crc_next[0]);
         end
         crc_next = crc_next & len_mask;
      end
   end

   always @* begin
      case (adr_i)
         `PCRC_CONTROL_ADDR: rd_data = {2'b00, idle_stop_reg, count_reg,
                                        full, empty, 1'b0, go_reg,
                                        poly_length_minus_one_reg};
         `PCRC_TAPS_ADDR:    rd_data = taps_reg;
         `PCRC_RESULT_ADDR:  rd_data = crc_reg & len_mask;
         default:            rd_data = 16'h0000;
      endcase
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         poly_length_minus_one_reg      <= 4'h0;
         go_reg        <= 1'b0;
         idle_stop_reg <= 1'b0;
         taps_reg      <= 16'h0000;
         crc_reg       <= 16'h0000;
         count_reg     <= 5'h00;
         wr_ptr_reg    <= 4'h0;
         rd_ptr_reg    <= 4'h0;
         shift_reg     <= 16'h0000;
         bit_reg       <= 4'h0;
         busy_reg      <= 1'b0;
         pend_irq_reg  <= 1'b0;
         ack_o         <= 1'b0;
         dat_o         <= 32'h0000_0000;
         irq_o         <= 1'b0;
      end else begin
         ack_o <= req;
         dat_o <= {16'h0000, rd_data};
         irq_o <= 1'b0;
         if (wr & (adr_i == `PCRC_CONTROL_ADDR)) begin
            if (sel_i[0]) begin
               poly_length_minus_one_reg <= dat_i[3:0];
               go_reg   <= dat_i[`PCRC_GO_BIT];
            end
            if (sel_i[1]) begin
               idle_stop_reg <= dat_i[`PCRC_IDLE_STOP_BIT];
            end
         end
         if (wr & (adr_i == `PCRC_TAPS_ADDR)) begin
            if (sel_i[0]) begin
               taps_reg[7:0] <= dat_i[7:0] & 8'hfe;
            end
            if (sel_i[1]) begin
               taps_reg[15:8] <= dat_i[15:8];
            end
         end
         if (wr & (adr_i == `PCRC_RESULT_ADDR)) begin
            crc_reg <= data_in & len_mask;
         end else begin
            crc_reg <= crc_next;
         end
         // Lower byte lanes land in the slot the next word fills.
         if (wr_data & ~frozen) begin
            if (sel_i[0]) begin
               fifo_mem[wr_ptr_reg][7:0] <= dat_i[7:0];
            end
            if (sel_i[1]) begin
               fifo_mem[wr_ptr_reg][15:8] <= dat_i[15:8];
            end
         end
         if (load) begin
            shift_reg <= fifo_mem[rd_ptr_reg];
            rd_ptr_reg <= rd_ptr_reg + 4'h1;
            bit_reg  <= poly_length_minus_one_reg;
            busy_reg <= 1'b1;
         end else if (run & busy_reg) begin
            shift_reg <= {shift_reg[14:0], 1'b0};
            bit_reg   <= bit_reg - 4'h1;
            if (bit_reg == 4'h0) begin
               busy_reg <= 1'b0;
            end
         end
         // A pending event is passed on even while frozen. A new event in
         // the same cycle is assigned below, so the set wins over the clear.
         if (pend_irq_reg) begin
            irq_o        <= 1'b1;
            pend_irq_reg <= 1'b0;
         end
         if (~frozen) begin
            if (word_in & full) begin
               count_reg  <= 5'h00;
               wr_ptr_reg <= 4'h0;
               rd_ptr_reg <= 4'h0;
               busy_reg   <= 1'b0;
            end else if (word_in & ~last_bit) begin
               count_reg  <= count_reg + 5'h01;
               wr_ptr_reg <= wr_ptr_reg + 4'h1;
            end else if (word_in & last_bit) begin
               wr_ptr_reg <= wr_ptr_reg + 4'h1;
            end else if (last_bit) begin
               count_reg <= count_reg - 5'h01;
               if (count_reg == 5'h01) begin
                  pend_irq_reg <= 1'b1;
               end
            end
         end
      end
   end
endmodule

// ### logic/pcrc_map.vh
// Register map, field positions and sizes of the CRC block.
// Assumes a 32-bit classic Wishbone slave; registers sit in the low 16 bits.
// Function
// - Checksum is the mod-2 remainder of the bit stream by the polynomial.
// - Taps bits 15..1 select polynomial terms; a 4-bit field selects length.
// - Term zero always fed back, top term implied at field plus one; tap bit 0 zero.
// - Length field holds length minus one; words are field plus one bits.
// - FIFO is 8 deep when length field exceeds 7, else 16 deep.
// - Data is written by byte or larger into the FIFO before shifting.
// - Word count rises by one when a write reaches the word's top bit.
// - Shifter runs only while go is set and the word count is nonzero.
// - Count drops after each word's last bit, bit 0; one clock per bit.
// - Clearing go stops the shifter; setting it starts the shifter.
// - Full flag at count equal depth; empty flag at count zero.
// - A write while full wraps the count to zero with no interrupt.
// - An interrupt fires when the word count goes from one to zero.
// - Sleep freezes the block in its current state until clock returns; pending events still pass.
// - Idle keeps running unless idle-stop is set; then freeze, pass events.
`ifndef PCRC_MAP_VH
`define PCRC_MAP_VH
`define PCRC_CONTROL_ADDR   4'h0
`define PCRC_TAPS_ADDR      4'h4
`define PCRC_WDATA_ADDR     4'h8
`define PCRC_RESULT_ADDR    4'hc
`define PCRC_POLY_LENGTH_MINUS_ONE_LSB       0
`define PCRC_GO_BIT         4
`define PCRC_EMPTY_BIT      6
`define PCRC_FULL_BIT       7
`define PCRC_COUNT_LSB      8
`define PCRC_IDLE_STOP_BIT  13
`define PCRC_DEPTH_SMALL    5'h08
`define PCRC_DEPTH_LARGE    5'h10
`define PCRC_POLY_LENGTH_MINUS_ONE_SPLIT     4'h7
`define PCRC_TAPS_MASK      16'hfffe
`endif
